//--- common/pcc_pkg.sv
// constants for the phone call control sequencer
package pcc_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned MS_PER_S = 1000;
	// interval figures in milliseconds
	localparam int unsigned CUT_MS = 2700;
	localparam int unsigned OVL_MS = 152;
	localparam int unsigned ABORT_LONG_MS = 18000;
	localparam int unsigned ABORT_SHORT_MS = 10000;
	localparam int unsigned LOC_MS = 500;
	localparam int unsigned DIAL_PULSE_MS = 60;
	localparam int unsigned DIAL_GAP_MS = 700;
	localparam int unsigned TONE_MS = 100;
	// a 1 ms tick drives every interval counter
	localparam int unsigned TICK_CYC = CLK_HZ / MS_PER_S;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] DIAL_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_OFS = 8'h0C;
	localparam logic [7:0] MASK_OFS = 8'h10;
	// control field positions
	localparam int unsigned C_AUTO = 0;
	localparam int unsigned C_LOC = 1;
	localparam int unsigned C_ABL = 2;
	localparam int unsigned C_RING = 4;
	localparam int unsigned C_HANG = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0011;
	// abort selection codes
	localparam logic [1:0] AB_NONE = 2'h0;
	localparam logic [1:0] AB_SHORT = 2'h1;
	localparam logic [1:0] AB_LONG = 2'h2;
	// dial command fields
	localparam int unsigned D_GO = 8;
	localparam int unsigned D_TONE = 9;
	// interrupt event bits
	localparam int unsigned E_CONN = 0;
	localparam int unsigned E_DISC = 1;
	localparam int unsigned E_OVL = 2;
	localparam int unsigned E_DIAL = 3;
	localparam int unsigned NEV = 4;
	typedef enum logic [2:0] {
		ST_ONHOOK = 3'b000,
		ST_DIAL = 3'b001,
		ST_CONN = 3'b010,
		ST_BUSY = 3'b011
	} pcc_state_t;
endpackage

//--- rtl/pcc_tick.sv
// prescaler producing a one-cycle enable every millisecond
`timescale 1ns/10ps
module pcc_tick import pcc_pkg::*; #(
	parameter int unsigned DIV = TICK_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// enable out
	output logic tick
);
	logic [31:0] cnt_reg;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (cnt_reg == DIV - 1) begin
			cnt_reg <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
			tick <= 1'b0;
		end
	end
endmodule // pcc_tick

//--- rtl/pcc_seq.sv
// call-control sequencer: answer, originate, dial, cut-through and disconnect timing
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
// Operation
// RULE1 - auto answer off-hook at ring end, ring count settable two or more
// RULE2 - manual answer pulse trailing edge answers without a ring
// RULE3 - manual originate pulse connects coupler to line
// RULE4 - line busy holds off-hook with audio path open
// RULE5 - automatic dialing by tone or pulse
// RULE6 - cut-through connects 2.7 s after line connection, not before
// RULE7 - sustained overload withdraws cut-through
// RULE8 - abort timer selectable long 18 s, short 10 s, or none
// RULE9 - abort expiry without carrier disconnects the line
// RULE10 - loss-of-carrier disconnect after 0.5 s when enabled
// RULE11 - loss-of-carrier and abort timer act independently
// RULE12 - all intervals counted from the fixed reference clock
module pcc_seq import pcc_pkg::*; #(
	parameter int unsigned TICK_DIV = TICK_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// user option inputs
	input wire logic ring_det,
	input wire logic man_answer,
	input wire logic man_orig,
	input wire logic line_busy,
	// modem module inputs
	input wire logic carrier_det,
	input wire logic overload_det,
	// line coupler and modem module outputs
	output logic off_hook,
	output logic audio_cut_through,
	output logic dtmf_en,
	output logic [3:0] dtmf_digit,
	// interrupt
	output logic irq
);
	logic tick;
	pcc_tick #(.DIV(TICK_DIV)) u_tick (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.tick(tick)
	);

	pcc_state_t state_reg;
	logic [31:0] ctrl_reg;
	logic [9:0] dial_reg;
	logic [NEV-1:0] ev_reg, mask_reg, ev_set;
	logic ring_q, ans_q, orig_q, ring_end, ans_fall, orig_rise;
	logic [3:0] ring_cnt_reg;
	logic [15:0] conn_ms_reg, ovl_ms_reg, loc_ms_reg, dial_ms_reg;
	logic [3:0] pulses_reg;
	logic dial_phase_reg, cut_hold_reg;
	logic disc, wr, rd;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	// edges are taken from registered copies; inputs are synchronous to ref_clk
	assign ring_end = ring_q && !ring_det;
	assign ans_fall = ans_q && !man_answer;
	assign orig_rise = man_orig && !orig_q;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ring_q <= 1'b0;
			ans_q <= 1'b0;
			orig_q <= 1'b0;
		end else begin
			ring_q <= ring_det;
			ans_q <= man_answer;
			orig_q <= man_orig;
		end
	end

	// register writes
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= CTRL_RST;
			mask_reg <= '0;
		end else if (wr && paddr == CTRL_OFS) begin
			ctrl_reg <= pwdata;
		end else if (wr && paddr == MASK_OFS) begin
			mask_reg <= pwdata[NEV-1:0];
		end
	end

	// disconnect decision: either timer alone suffices
	always_comb begin
		disc = 1'b0;
		if (ctrl_reg[C_HANG])
			disc = 1'b0;
		if (ctrl_reg[C_ABL+:2] == AB_LONG && conn_ms_reg == 16'(ABORT_LONG_MS) && !carrier_det)
			disc = 1'b1; // [RULE8] [RULE9] [RULE11]
		if (ctrl_reg[C_ABL+:2] == AB_SHORT && conn_ms_reg == 16'(ABORT_SHORT_MS) && !carrier_det)
			disc = 1'b1; // [RULE8] [RULE9] [RULE11]
		if (ctrl_reg[C_LOC] && loc_ms_reg >= 16'(LOC_MS))
			disc = 1'b1; // [RULE10] [RULE11]
	end

	// call state machine
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_ONHOOK;
			ring_cnt_reg <= 4'h0;
			dial_reg <= '0;
		end else begin
			if (wr && paddr == DIAL_OFS && state_reg == ST_ONHOOK)
				dial_reg <= pwdata[9:0];
			unique case (state_reg)
				ST_ONHOOK: begin
					if (line_busy) begin
						state_reg <= ST_BUSY; // [RULE4]
					end else if (ans_fall || orig_rise) begin
						state_reg <= ST_CONN; // [RULE2] [RULE3]
						ring_cnt_reg <= 4'h0;
					end else if (ctrl_reg[C_AUTO] && ring_end) begin
						// a count of 0 or 1 answers on the first ring
						if (ring_cnt_reg + 4'h1 >= ctrl_reg[C_RING+:4]) begin
							state_reg <= ST_CONN; // [RULE1]
							ring_cnt_reg <= 4'h0;
						end else begin
							ring_cnt_reg <= ring_cnt_reg + 4'h1; // [RULE1]
						end
					end else if (wr && paddr == DIAL_OFS && pwdata[D_GO]) begin
						state_reg <= ST_DIAL; // [RULE5]
					end
				end
				ST_DIAL: begin
					if (line_busy)
						state_reg <= ST_BUSY;
					else if (tick && dial_phase_reg && dial_ms_reg == 16'(DIAL_GAP_MS))
						state_reg <= ST_CONN; // [RULE5]
				end
				ST_CONN: begin
					if (line_busy)
						state_reg <= ST_BUSY;
					else if (disc || ctrl_reg[C_HANG])
						state_reg <= ST_ONHOOK;
				end
				ST_BUSY: begin
					if (!line_busy)
						state_reg <= ST_ONHOOK;
				end
				default: state_reg <= ST_ONHOOK;
			endcase
		end
	end

	// dialer: tone burst, or a train of break pulses, then an inter-digit gap
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dial_ms_reg <= '0;
			pulses_reg <= 4'h0;
			dial_phase_reg <= 1'b0;
			dtmf_en <= 1'b0;
			dtmf_digit <= 4'h0;
		end else if (state_reg != ST_DIAL) begin
			dial_ms_reg <= '0;
			pulses_reg <= 4'h0;
			dial_phase_reg <= 1'b0;
			dtmf_en <= 1'b0;
		end else if (tick) begin
			dial_ms_reg <= dial_ms_reg + 16'h0001;
			if (!dial_phase_reg && dial_reg[D_TONE]) begin
				dtmf_en <= 1'b1; // [RULE5]
				dtmf_digit <= dial_reg[3:0];
				if (dial_ms_reg == 16'(TONE_MS)) begin
					dtmf_en <= 1'b0;
					dial_phase_reg <= 1'b1;
					dial_ms_reg <= '0;
				end
			end else if (!dial_phase_reg) begin
				// digit 0 sends ten pulses
				if (dial_ms_reg == 16'(2 * DIAL_PULSE_MS)) begin
					dial_ms_reg <= '0;
					pulses_reg <= pulses_reg + 4'h1; // [RULE5]
					if (pulses_reg + 4'h1 == ((dial_reg[3:0] == 4'h0) ? 4'hA : dial_reg[3:0]))
						dial_phase_reg <= 1'b1;
				end
			end
		end
	end

	// connection, overload and carrier-loss timers in milliseconds
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			conn_ms_reg <= '0;
			ovl_ms_reg <= '0;
			loc_ms_reg <= '0;
			cut_hold_reg <= 1'b0;
		end else if (state_reg != ST_CONN) begin
			conn_ms_reg <= '0;
			ovl_ms_reg <= '0;
			loc_ms_reg <= '0;
			cut_hold_reg <= 1'b0;
		end else if (tick) begin
			if (conn_ms_reg != 16'hFFFF)
				conn_ms_reg <= conn_ms_reg + 16'h0001; // [RULE12]
			ovl_ms_reg <= overload_det ? ovl_ms_reg + 16'h0001 : 16'h0000;
			if (overload_det && ovl_ms_reg == 16'(OVL_MS - 1))
				cut_hold_reg <= 1'b1; // [RULE7]
			else if (!overload_det)
				cut_hold_reg <= 1'b0;
			loc_ms_reg <= (carrier_det || loc_ms_reg == 16'hFFFF) ? 16'h0000 : loc_ms_reg + 16'h0001;
		end
	end

	// line outputs; each pulse period makes first, then breaks, so the first break is seen after seizure
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			off_hook <= 1'b0;
			audio_cut_through <= 1'b0;
		end else begin
			off_hook <= (state_reg == ST_CONN) || (state_reg == ST_BUSY) || // [RULE4]
				(state_reg == ST_DIAL && (dial_reg[D_TONE] || dial_phase_reg || dial_ms_reg < 16'(DIAL_PULSE_MS)));
			audio_cut_through <= (state_reg == ST_CONN) && conn_ms_reg >= 16'(CUT_MS) && !cut_hold_reg; // [RULE6] [RULE7]
		end
	end

	// events are sticky; a read clears only the bits it returned, so an event landing mid-read is kept
	always_comb begin
		ev_set = '0;
		ev_set[E_CONN] = state_reg == ST_CONN && tick && conn_ms_reg == 16'(CUT_MS);
		ev_set[E_DISC] = state_reg == ST_CONN && disc;
		ev_set[E_OVL] = tick && overload_det && state_reg == ST_CONN && ovl_ms_reg == 16'(OVL_MS - 1);
		ev_set[E_DIAL] = state_reg == ST_DIAL && tick && dial_phase_reg && dial_ms_reg == 16'(DIAL_GAP_MS);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ev_reg <= '0;
			irq <= 1'b0;
		end else begin
			ev_reg <= ((rd && paddr == IRQ_OFS) ? (ev_reg & ~prdata[NEV-1:0]) : ev_reg) | ev_set;
			irq <= |(ev_reg & mask_reg);
		end
	end

	// apb read data and response; zero wait states
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !(paddr == CTRL_OFS || paddr == DIAL_OFS ||
				paddr == STAT_OFS || paddr == IRQ_OFS || paddr == MASK_OFS);
			unique case (paddr)
				CTRL_OFS: prdata <= ctrl_reg;
				DIAL_OFS: prdata <= {22'h0, dial_reg};
				STAT_OFS: prdata <= {24'h0, carrier_det, line_busy, audio_cut_through, off_hook,
					1'b0, state_reg};
				IRQ_OFS: prdata <= {28'h0, ev_reg};
				MASK_OFS: prdata <= {28'h0, mask_reg};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // pcc_seq

//--- tb/pcc_seq_sva.sv
// assertion checker on the call-control sequencer ports
`timescale 1ns/10ps
module pcc_seq_chk import pcc_pkg::*; #(
	parameter int unsigned TICK_DIV = TICK_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// line side
	input wire logic man_answer,
	input wire logic man_orig,
	input wire logic line_busy,
	input wire logic overload_det,
	input wire logic off_hook,
	input wire logic audio_cut_through,
	input wire logic dtmf_en
);
	// lower tolerance edge, so tick phase never trips the check
	localparam int unsigned CUT_MIN = CUT_MS * TICK_DIV * 4 / 5;
	localparam int unsigned OVL_MAX = (OVL_MS + 2) * TICK_DIV;
	int unsigned hook_cnt;
	int unsigned ovl_cnt;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hook_cnt <= 0;
		end else if (!off_hook) begin
			hook_cnt <= 0;
		end else if (hook_cnt < CUT_MIN) begin
			hook_cnt <= hook_cnt + 1;
		end
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ovl_cnt <= 0;
		end else if (!overload_det) begin
			ovl_cnt <= 0;
		end else if (ovl_cnt <= OVL_MAX) begin
			ovl_cnt <= ovl_cnt + 1;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable && pready; endsequence
	property p_apb_ready; s_setup |=> s_access; endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("apb access not answered next cycle");
	property p_apb_err; s_access |-> pslverr == (paddr > MASK_OFS || paddr[1:0] != 2'b00); endproperty
	a_apb_err: assert property (p_apb_err) else $error("slave error does not match the address map");
	property p_busy; line_busy [*3] |-> off_hook && !audio_cut_through; endproperty
	a_busy: assert property (p_busy) else $error("busy line not held off-hook and open");
	property p_answer; $fell(man_answer) && !off_hook && !line_busy |-> ##[1:3] off_hook; endproperty
	a_answer: assert property (p_answer) else $error("manual answer ignored");
	property p_orig; $rose(man_orig) && !off_hook && !line_busy |-> ##[1:3] off_hook; endproperty
	a_orig: assert property (p_orig) else $error("manual originate ignored");
	property p_cut; $rose(audio_cut_through) |-> hook_cnt >= CUT_MIN; endproperty
	a_cut: assert property (p_cut) else $error("cut-through made too early");
	property p_ovl; ovl_cnt > OVL_MAX |-> !audio_cut_through; endproperty
	a_ovl: assert property (p_ovl) else $error("cut-through kept under overload");
	property p_tone; dtmf_en |-> off_hook && !audio_cut_through; endproperty
	a_tone: assert property (p_tone) else $error("tone sent while on-hook or cut through");
endmodule // pcc_seq_chk

bind pcc_seq pcc_seq_chk #(.TICK_DIV(TICK_DIV)) u_pcc_seq_chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.man_answer(man_answer), .man_orig(man_orig), .line_busy(line_busy), .overload_det(overload_det),
	.off_hook(off_hook), .audio_cut_through(audio_cut_through), .dtmf_en(dtmf_en));

//--- tb/pcc_line_model.sv
// line coupler and modem module model: rings, carrier, overload
`timescale 1ns/10ps
module pcc_line_model #(
	parameter int unsigned RING_ON = 40,
	parameter int unsigned RING_OFF = 60
) (
	// clock
	input wire logic ref_clk,
	// bench controls
	input wire logic ring_go,
	input wire logic [3:0] ring_cnt,
	input wire logic carrier_on,
	input wire logic ovl_on,
	// device side
	input wire logic off_hook,
	output logic ring_det = 1'b0,
	output logic carrier_det = 1'b0,
	output logic overload_det = 1'b0
);
	int unsigned left = 0;
	int unsigned ph = 0;
	always @(posedge ref_clk) begin
		if (ring_go) begin
			left <= ring_cnt;
			ph <= 0;
		end else if (left != 0) begin
			ph <= (ph == RING_ON + RING_OFF - 1) ? 0 : ph + 1;
			left <= (ph == RING_ON + RING_OFF - 1) ? left - 1 : left;
		end
		// ringing stops once the line is answered, as on a real exchange
		ring_det <= left != 0 && !ring_go && ph < RING_ON && !off_hook;
		carrier_det <= carrier_on && off_hook;
		overload_det <= ovl_on;
	end
endmodule // pcc_line_model

//--- tb/phone_call_control_sequencer_tb_top.sv
// random and corner-case bench for the call-control sequencer
`timescale 1ns/10ps
module phone_call_control_sequencer_tb_top import pcc_pkg::*;;
	localparam int unsigned TD = 2;
	logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, h;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, seed = 32'hF52A88E6;
	logic man_answer = 0, man_orig = 0, line_busy = 0, ring_go = 0, carrier_on = 0, ovl_on = 0;
	logic [3:0] ring_cnt = 0, dtmf_digit, dg;
	logic ring_det, carrier_det, overload_det, off_hook, audio_cut_through, dtmf_en, irq;
	logic [1:0] abc [2] = '{AB_SHORT, AB_LONG};
	int unsigned abms [2] = '{ABORT_SHORT_MS, ABORT_LONG_MS};
	int bad_count = 0, check_count = 0, n, k;
	always #2.5 ref_clk = ~ref_clk;
	pcc_seq #(.TICK_DIV(TD)) u_pcc_seq (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ring_det(ring_det), .man_answer(man_answer), .man_orig(man_orig), .line_busy(line_busy),
		.carrier_det(carrier_det), .overload_det(overload_det), .off_hook(off_hook),
		.audio_cut_through(audio_cut_through), .dtmf_en(dtmf_en), .dtmf_digit(dtmf_digit), .irq(irq));
	pcc_line_model u_pcc_line_model (.ref_clk(ref_clk), .ring_go(ring_go), .ring_cnt(ring_cnt),
		.carrier_on(carrier_on), .ovl_on(ovl_on), .off_hook(off_hook), .ring_det(ring_det),
		.carrier_det(carrier_det), .overload_det(overload_det));
	function automatic logic [31:0] xs(logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic cyc(int c);
		repeat (c) @(posedge ref_clk);
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pin(string nm, logic e, logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
		int t;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		t = 0;
		do begin
			@(posedge ref_clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		r = prdata;
		e = pslverr;
		pin("pready", 1'b1, pready);
		psel <= 0;
		penable <= 0;
		@(posedge ref_clk);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d, rd, err);
	endtask
	task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0, rd, err);
		chk(nm, e, rd);
	endtask
	task automatic hang(logic [31:0] c);
		wr(CTRL_OFS, c | (32'h1 << C_HANG));
		wr(CTRL_OFS, c);
		cyc(4);
		pin("off_hook", 1'b0, off_hook);
	endtask
	task automatic summarize();
		if (bad_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#480us;
		bad_count++;
		summarize();
	end
	initial begin
		cyc(3);
		reset_n <= 1;
		rdc("ctrl", CTRL_OFS, CTRL_RST);
		apb(1'b0, 8'h14, 32'h0, rd, err);
		pin("slverr", 1'b1, err);
		wr(MASK_OFS, 32'h0);
		man_answer <= 1;
		cyc(2);
		man_answer <= 0;
		cyc(4);
		pin("off_hook", 1'b1, off_hook);
		cyc(CUT_MS * TD * 4 / 5 - 40);
		pin("cut", 1'b0, audio_cut_through);
		cyc(CUT_MS * TD * 2 / 5);
		pin("cut", 1'b1, audio_cut_through);
		pin("irq", 1'b0, irq);
		wr(MASK_OFS, 32'h1 << E_CONN);
		cyc(1);
		pin("irq", 1'b1, irq);
		rdc("irq_stat", IRQ_OFS, 32'h1 << E_CONN);
		cyc(2);
		pin("irq", 1'b0, irq);
		ovl_on <= 1;
		cyc(OVL_MS * TD * 4 / 5);
		pin("cut", 1'b1, audio_cut_through);
		cyc(OVL_MS * TD * 2 / 5);
		pin("cut", 1'b0, audio_cut_through);
		ovl_on <= 0;
		hang(CTRL_RST);
		line_busy <= 1;
		cyc(CUT_MS * TD * 6 / 5);
		pin("off_hook", 1'b1, off_hook);
		pin("cut", 1'b0, audio_cut_through);
		rdc("stat", STAT_OFS, 32'h0000_0053);
		line_busy <= 0;
		hang(CTRL_RST);
		seed = xs(seed);
		n = 2 + seed % 3;
		wr(CTRL_OFS, 32'h1 | (n << C_RING));
		ring_cnt <= n[3:0];
		ring_go <= 1;
		cyc(1);
		ring_go <= 0;
		cyc((n - 1) * 100 + 20);
		pin("off_hook", 1'b0, off_hook);
		cyc(80);
		pin("off_hook", 1'b1, off_hook);
		hang(CTRL_RST);
		for (int i = 0; i < 2; i++) begin
			wr(CTRL_OFS, CTRL_RST | ({30'h0, abc[i]} << C_ABL));
			man_orig <= 1;
			cyc(2);
			man_orig <= 0;
			cyc(4);
			pin("off_hook", 1'b1, off_hook);
			cyc((abms[i] - 10) * TD);
			pin("off_hook", 1'b1, off_hook);
			cyc(20 * TD);
			pin("off_hook", 1'b0, off_hook);
		end
		for (int i = 0; i < 2; i++) begin
			wr(CTRL_OFS, CTRL_RST | (i << C_LOC));
			carrier_on <= 1;
			man_orig <= 1;
			cyc(2);
			man_orig <= 0;
			cyc(100 * TD);
			carrier_on <= 0;
			cyc((LOC_MS - 10) * TD);
			pin("off_hook", 1'b1, off_hook);
			cyc(20 * TD);
			pin("off_hook", i == 0, off_hook);
			hang(CTRL_RST);
		end
		for (int i = 0; i < 2; i++) begin
			seed = xs(seed);
			n = 1 + seed % 9;
			k = 0;
			dg = 0;
			wr(DIAL_OFS, n | (1 << D_GO) | ((1 - i) << D_TONE));
			repeat ((n * 120 + DIAL_GAP_MS + 20) * TD) begin
				h = off_hook;
				@(posedge ref_clk);
				k += (h && !off_hook) ? 1 : 0;
				dg = (dtmf_en === 1'b1) ? dtmf_digit : dg;
			end
			chk("breaks", (i == 1) ? n : 0, k);
			chk("digit", (i == 0) ? n : 0, {28'h0, dg});
			pin("off_hook", 1'b1, off_hook);
			hang(CTRL_RST);
		end
		summarize();
	end
endmodule // phone_call_control_sequencer_tb_top
